// File: hdl/rst_seq_pkg.sv
// constants and carrier types for the reset initialization sequencer
package rst_seq_pkg;
   localparam int unsigned PORST_MIN_CYC    = 32;
   localparam int unsigned HARD_ASSERT_CYC  = 512;
   localparam int unsigned SOFT_LAG_CYC     = 16;
   localparam int unsigned CFG_SETUP_CYC    = 4;
   localparam int unsigned CFG_TURNON_CYC   = 1;
   localparam int unsigned CLK_PERIOD_NS    = 8;
   localparam int unsigned CFG_OFF_MAX_NS   = 4;
   // longest time rounds down, but never below one cycle
   localparam int unsigned CFG_OFF_CYC      =
      (CFG_OFF_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
      (CFG_OFF_MAX_NS / CLK_PERIOD_NS);
   localparam int unsigned DLL_LOCK_MIN_CYC = 7680;
   localparam int unsigned DLL_LOCK_MAX_CYC = 122880;
   localparam int unsigned SRC_W            = 3;
   localparam int unsigned CNT_W            = 17;
   localparam logic [SRC_W-1:0] SRC_RST     = 3'h0;
   localparam logic         DIV_RST         = 1'h0;

   typedef struct packed {
      logic [SRC_W-1:0] reset_source;
      logic             clk_divide;
   } boot_cfg_t;

   typedef enum logic [4:0] {
      ST_POR   = 5'h01,
      ST_HARD  = 5'h02,
      ST_SOFT  = 5'h04,
      ST_DLL   = 5'h08,
      ST_RUN   = 5'h10
   } seq_state_t;
endpackage : rst_seq_pkg

// File: hdl/reset_init_sequencer.sv
// reset initialization sequencer: hard/soft reset drive and boot straps
`timescale 1ns/1ps
module reset_init_sequencer #(
   parameter int unsigned HARD_CYC = rst_seq_pkg::HARD_ASSERT_CYC,
   parameter int unsigned SOFT_CYC = rst_seq_pkg::SOFT_LAG_CYC,
   parameter int unsigned DLL_MIN  = rst_seq_pkg::DLL_LOCK_MIN_CYC,
   parameter int unsigned DLL_MAX  = rst_seq_pkg::DLL_LOCK_MAX_CYC
) (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // reset pins
   input  wire logic                  power_on_reset_in_n,
   input  wire logic                  hard_reset_line_n_i,
   output logic                       hard_reset_line_n_o,
   output logic                       hard_reset_line_oe_n,
   input  wire logic                  soft_reset_line_n_i,
   output logic                       soft_reset_line_n_o,
   output logic                       soft_reset_line_oe_n,
   // mode and clocking
   input  wire logic                  pci_host_mode,
   input  wire logic                  bus_sync_tick,
   input  wire logic                  dll_locked,
   output logic                       main_clk_sel_primary,
   output logic                       bus_sync_div2,
   // boot straps
   input  wire rst_seq_pkg::boot_cfg_t cfg_pin_i,
   output rst_seq_pkg::boot_cfg_t     cfg_pin_o,
   output logic                       cfg_pin_oe_n,
   output rst_seq_pkg::boot_cfg_t     boot_cfg,
   // status
   output logic                       dll_lock_err,
   output logic                       ready
);
   logic [2:0] por_s_q;
   logic [1:0] hrst_s_q, hard_dly_q;
   rst_seq_pkg::boot_cfg_t cfg_s1_q, cfg_s2_q;
   rst_seq_pkg::seq_state_t st_q, st_d;
   logic [rst_seq_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic hard_q, hard_d, soft_q, soft_d, cfgoe_q, cfgoe_d;
   logic err_q, err_d, rdy_q, rdy_d;
   rst_seq_pkg::boot_cfg_t bcfg_q, bcfg_d;
   logic host_q, host_d;
   logic hard_oe_n_q, hard_oe_n_d, soft_oe_n_q, soft_oe_n_d;
   logic cfg_oe_n_q, cfg_oe_n_d, div2_q, div2_d;
   logic por_act, por_rel, ext_hard;

   // two-flop synchronisers; the second stage is read, and power-on also reads a third flop for its release edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         por_s_q  <= 3'h0;
         hrst_s_q <= 2'h0;
         hard_dly_q <= 2'h3;
         cfg_s1_q <= '0;
         cfg_s2_q <= '0;
      end else begin
         por_s_q  <= {por_s_q[1:0], ~power_on_reset_in_n};
         hrst_s_q <= {hrst_s_q[0], ~hard_reset_line_n_i};
         hard_dly_q <= {hard_dly_q[0], hard_q};
         cfg_s1_q <= cfg_pin_i;
         cfg_s2_q <= cfg_s1_q;
      end
   end
   assign por_act  = por_s_q[1];
   assign por_rel  = por_s_q[2] & ~por_s_q[1];
   // an external hard reset pulse restarts the sequence from ST_HARD; our own pull
   // shows on the synced pin two edges late, so it is masked that long
   assign ext_hard = hrst_s_q[1] & ~hard_q & ~hard_dly_q[1];

   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      hard_d  = hard_q;
      soft_d  = soft_q;
      cfgoe_d = cfgoe_q;
      err_d   = err_q;
      rdy_d   = rdy_q;
      bcfg_d  = bcfg_q;
      host_d  = host_q;
      if (por_act) begin
         st_d    = rst_seq_pkg::ST_POR;
         err_d   = 1'b0;
         hard_d  = 1'b1;
         soft_d  = 1'b1;
         cfgoe_d = 1'b0;
         rdy_d   = 1'b0;
         cnt_d   = '0;
      end else if (ext_hard && st_q != rst_seq_pkg::ST_POR) begin
         st_d    = rst_seq_pkg::ST_HARD;
         hard_d  = 1'b1;
         soft_d  = 1'b1;
         cfgoe_d = 1'b0;
         rdy_d   = 1'b0;
         cnt_d   = '0;
      end else begin
         case (st_q)
            rst_seq_pkg::ST_POR: begin
               if (por_rel) begin
                  // straps latched at release; board kept them stable
                  bcfg_d = cfg_s2_q;
                  host_d = pci_host_mode;
                  st_d   = rst_seq_pkg::ST_HARD;
                  cnt_d  = '0;
               end
            end
            rst_seq_pkg::ST_HARD: begin
               if (bus_sync_tick) begin
                  cnt_d = cnt_q + 1'b1;
               end
               if (cnt_q >= HARD_CYC[rst_seq_pkg::CNT_W-1:0]) begin
                  hard_d = 1'b0;
                  st_d   = rst_seq_pkg::ST_SOFT;
                  cnt_d  = '0;
               end
            end
            rst_seq_pkg::ST_SOFT: begin
               if (bus_sync_tick) begin
                  cnt_d = cnt_q + 1'b1;
               end
               // at least one tick before straps are driven again
               if (cnt_q >= rst_seq_pkg::CFG_TURNON_CYC) begin
                  cfgoe_d = 1'b1;
               end
               if (cnt_q >= SOFT_CYC[rst_seq_pkg::CNT_W-1:0]) begin
                  soft_d = 1'b0;
                  st_d   = rst_seq_pkg::ST_DLL;
                  cnt_d  = '0;
               end
            end
            rst_seq_pkg::ST_DLL: begin
               // system bus cycles, so counted on every core edge
               cnt_d = cnt_q + 1'b1;
               if (dll_locked &&
                   cnt_q >= DLL_MIN[rst_seq_pkg::CNT_W-1:0]) begin
                  st_d  = rst_seq_pkg::ST_RUN;
                  rdy_d = 1'b1;
               end else if (cnt_q >= DLL_MAX[rst_seq_pkg::CNT_W-1:0]) begin
                  st_d  = rst_seq_pkg::ST_RUN;
                  err_d = 1'b1;
                  rdy_d = 1'b1;
               end
            end
            rst_seq_pkg::ST_RUN: begin
               st_d = rst_seq_pkg::ST_RUN;
            end
            default: begin
               st_d = rst_seq_pkg::ST_POR;
            end
         endcase
      end
      hard_oe_n_d = ~hard_d;
      soft_oe_n_d = ~soft_d;
      cfg_oe_n_d  = ~cfgoe_d;
      div2_d      = host_d & bcfg_d.clk_divide;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_q    <= rst_seq_pkg::ST_POR;
         cnt_q   <= '0;
         hard_q  <= 1'b1;
         soft_q  <= 1'b1;
         cfgoe_q <= 1'b0;
         err_q   <= 1'b0;
         rdy_q   <= 1'b0;
         bcfg_q  <= '{reset_source: rst_seq_pkg::SRC_RST,
                      clk_divide: rst_seq_pkg::DIV_RST};
         host_q  <= 1'b1;
         hard_oe_n_q <= 1'b0;
         soft_oe_n_q <= 1'b0;
         cfg_oe_n_q  <= 1'b1;
         div2_q      <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         hard_q  <= hard_d;
         soft_q  <= soft_d;
         cfgoe_q <= cfgoe_d;
         err_q   <= err_d;
         rdy_q   <= rdy_d;
         bcfg_q  <= bcfg_d;
         host_q  <= host_d;
         hard_oe_n_q <= hard_oe_n_d;
         soft_oe_n_q <= soft_oe_n_d;
         cfg_oe_n_q  <= cfg_oe_n_d;
         div2_q      <= div2_d;
      end
   end

   // open drain: output level is always low, enable low means pulling
   assign hard_reset_line_n_o  = 1'b0;
   assign soft_reset_line_n_o  = 1'b0;
   assign hard_reset_line_oe_n = hard_oe_n_q;
   assign soft_reset_line_oe_n = soft_oe_n_q;
   assign cfg_pin_oe_n         = cfg_oe_n_q;
   assign cfg_pin_o            = bcfg_q;
   assign boot_cfg             = bcfg_q;
   assign main_clk_sel_primary = host_q;
   assign bus_sync_div2        = div2_q;
   assign dll_lock_err         = err_q;
   assign ready                = rdy_q;

   // checks
   logic [9:0] hold_cnt_q, lag_cnt_q;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hold_cnt_q <= '0;
      end else if (!hard_q) begin
         hold_cnt_q <= '0;
      end else if (bus_sync_tick && hold_cnt_q != 10'h3ff) begin
         hold_cnt_q <= hold_cnt_q + 10'h001;
      end
   end

   // ticks since hard reset was released, for the soft lag and strap checks
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lag_cnt_q <= '0;
      end else if (hard_q) begin
         lag_cnt_q <= '0;
      end else if (bus_sync_tick && lag_cnt_q != 10'h3ff) begin
         lag_cnt_q <= lag_cnt_q + 10'h001;
      end
   end

   sequence hard_fall_s;
      $fell(hard_q);
   endsequence

   hard_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      hard_fall_s |-> $past(hold_cnt_q) >= 10'(HARD_CYC))
      else $error("hard reset released too early");

   soft_after_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(soft_q) |-> !hard_q)
      else $error("soft reset released before hard reset");

   soft_lag_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(soft_q) |-> $past(lag_cnt_q) >= 10'(SOFT_CYC))
      else $error("soft reset released with too little lag");

   cfg_off_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(hard_q) |-> !cfgoe_q)
      else $error("straps still driven during hard reset");

   cfg_on_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(cfgoe_q) |-> !hard_q &&
      $past(lag_cnt_q) >= 10'(rst_seq_pkg::CFG_TURNON_CYC))
      else $error("straps driven too soon after hard reset");

   drive_low_a: assert property (@(posedge core_clk) disable iff (rst)
      !hard_reset_line_n_o && !soft_reset_line_n_o)
      else $error("reset line driven high");

   div_sel_a: assert property (@(posedge core_clk) disable iff (rst)
      bus_sync_div2 == (main_clk_sel_primary && boot_cfg.clk_divide))
      else $error("bus sync divide mismatch");

   dll_wait_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(ready) |-> $past(cnt_q) >= 17'(DLL_MIN) || dll_lock_err)
      else $error("ready before minimum dll lock time");

   latch_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_q == rst_seq_pkg::ST_POR && por_rel && !por_act)
      |=> boot_cfg == $past(cfg_s2_q))
      else $error("boot straps not latched at release");
endmodule : reset_init_sequencer

// File: sim/board_reset_model.sv
// board side: power-on reset source, strap drivers, reset line pull-ups
`timescale 1ns/1ps
module board_reset_model #(
   parameter int unsigned POR_TICKS = rst_seq_pkg::PORST_MIN_CYC
) (
   // clock
   input  wire logic                   core_clk,
   // device drives
   input  wire logic                   hard_oe_n,
   input  wire logic                   soft_oe_n,
   input  wire logic                   cfg_oe_n,
   input  wire rst_seq_pkg::boot_cfg_t cfg_o,
   // resolved pins
   output logic                        por_n = 1'b0,
   output logic                        hard_line_n,
   output logic                        soft_line_n,
   output rst_seq_pkg::boot_cfg_t      cfg_pin,
   output logic                        tick = 1'b0
);
   logic                   ext_pull  = 1'b0;
   logic                   strap_drv = 1'b1;
   rst_seq_pkg::boot_cfg_t straps    = 4'h0;
   // pull-ups: an unknown enable counts as pulling low
   assign hard_line_n = (hard_oe_n === 1'b1) && !ext_pull;
   assign soft_line_n = (soft_oe_n === 1'b1);
   // released straps show the inverse so a stale value is never read
   assign cfg_pin = strap_drv ? straps :
                    (cfg_oe_n === 1'b0 ? cfg_o : ~straps);
   // bus sync clock runs free, stable before power-on release
   always @(posedge core_clk) begin
      #1;
      tick = ~tick;
   end
   always @(posedge core_clk) begin
      #1;
      if (por_n && !ext_pull && hard_line_n) strap_drv = 1'b0;
   end
   task power_on(input rst_seq_pkg::boot_cfg_t c);
      int n;
      begin
         @(posedge core_clk);
         #1;
         por_n = 1'b0;
         strap_drv = 1'b1;
         straps = c;
         n = 0;
         while (n < POR_TICKS) begin
            @(posedge core_clk);
            if (tick) n++;
         end
         #1;
         por_n = 1'b1;
      end
   endtask : power_on
   task hard_pull(input int ticks);
      int n;
      begin
         @(posedge core_clk);
         #1;
         ext_pull = 1'b1;
         strap_drv = 1'b1;
         straps = ~straps;
         n = 0;
         while (n < ticks) begin
            @(posedge core_clk);
            if (tick) n++;
         end
         #1;
         ext_pull = 1'b0;
      end
   endtask : hard_pull
endmodule : board_reset_model

// File: sim/test_reset_init_sequencer.sv
// self-checking bench for the reset initialization sequencer
`timescale 1ns/1ps
`define check_eq(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
   end end
module test_reset_init_sequencer;
   localparam int unsigned HC = 8;
   localparam int unsigned SC = 4;
   localparam int unsigned DM = 10;
   localparam int unsigned DX = 40;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic pci_host_mode = 1'b0;
   logic dll_locked = 1'b0;
   logic por_n, hard_line_n, soft_line_n, tick, hprev, sprev, cprev;
   logic hard_reset_line_n_o, hard_reset_line_oe_n, soft_reset_line_n_o;
   logic soft_reset_line_oe_n, main_clk_sel_primary, bus_sync_div2;
   logic cfg_pin_oe_n, dll_lock_err, ready;
   rst_seq_pkg::boot_cfg_t cfg_pin, cfg_pin_o, boot_cfg;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int hticks = 0;
   int rticks = 0;
   int dll_n = 0;
   always #4 core_clk = ~core_clk;
   reset_init_sequencer #(.HARD_CYC(HC), .SOFT_CYC(SC), .DLL_MIN(DM),
      .DLL_MAX(DX)) u_dut (.core_clk(core_clk), .rst(rst),
      .power_on_reset_in_n(por_n), .hard_reset_line_n_i(hard_line_n),
      .hard_reset_line_n_o(hard_reset_line_n_o),
      .hard_reset_line_oe_n(hard_reset_line_oe_n),
      .soft_reset_line_n_i(soft_line_n),
      .soft_reset_line_n_o(soft_reset_line_n_o),
      .soft_reset_line_oe_n(soft_reset_line_oe_n),
      .pci_host_mode(pci_host_mode), .bus_sync_tick(tick),
      .dll_locked(dll_locked), .main_clk_sel_primary(main_clk_sel_primary),
      .bus_sync_div2(bus_sync_div2), .cfg_pin_i(cfg_pin),
      .cfg_pin_o(cfg_pin_o), .cfg_pin_oe_n(cfg_pin_oe_n),
      .boot_cfg(boot_cfg), .dll_lock_err(dll_lock_err), .ready(ready));
   board_reset_model u_board (.core_clk(core_clk),
      .hard_oe_n(hard_reset_line_oe_n), .soft_oe_n(soft_reset_line_oe_n),
      .cfg_oe_n(cfg_pin_oe_n), .cfg_o(cfg_pin_o), .por_n(por_n),
      .hard_line_n(hard_line_n), .soft_line_n(soft_line_n),
      .cfg_pin(cfg_pin), .tick(tick));
   // interval monitors; a new hard request restarts the hold count
   always @(posedge core_clk) begin
      hprev <= hard_reset_line_oe_n;
      sprev <= soft_reset_line_oe_n;
      cprev <= cfg_pin_oe_n;
      if (!por_n || hard_reset_line_oe_n) hticks <= 0;
      else if (tick) hticks <= hticks + 1;
      if (!hard_reset_line_oe_n) rticks <= 0;
      else if (tick) rticks <= rticks + 1;
      if (!soft_reset_line_oe_n) dll_n <= 0;
      else if (!ready) dll_n <= dll_n + 1;
      if (hard_reset_line_oe_n && hprev === 1'b0)
         `check_eq(hticks >= HC, 1'b1)
      if (soft_reset_line_oe_n && sprev === 1'b0)
         `check_eq(rticks >= SC, 1'b1)
      if (!cfg_pin_oe_n && cprev === 1'b1)
         `check_eq(rticks >= 1, 1'b1)
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         conclude();
      end
   end
   task wait_ready;
      int n;
      begin
         n = 0;
         while (ready !== 1'b1 && n < 600) begin
            @(posedge core_clk);
            n++;
         end
         #1;
         `check_eq(ready, 1'b1)
      end
   endtask : wait_ready
   task run_seq(input rst_seq_pkg::boot_cfg_t c, input logic host,
                input logic lock);
      int lo;
      begin
         lo = lock ? DM : DX;
         @(posedge core_clk);
         #1;
         pci_host_mode = host;
         dll_locked = lock;
         u_board.power_on(c);
         wait_ready();
         `check_eq((dll_n >= lo) && (dll_n <= lo + 3), 1'b1)
         `check_eq(dll_lock_err, !lock)
         `check_eq(boot_cfg, c)
         `check_eq(cfg_pin_o, c)
         `check_eq(cfg_pin_oe_n, 1'b0)
         `check_eq(bus_sync_div2, host & c.clk_divide)
         `check_eq(main_clk_sel_primary, host)
         `check_eq({hard_reset_line_n_o, soft_reset_line_n_o}, 2'h0)
      end
   endtask : run_seq
   // the board flips its straps here; they must not be taken again
   task ext_hard;
      begin
         @(posedge core_clk);
         #1;
         dll_locked = 1'b1;
         fork
            u_board.hard_pull(3);
            begin
               repeat (5) @(posedge core_clk);
               #1;
               `check_eq(cfg_pin_oe_n, 1'b1)
               `check_eq(hard_reset_line_oe_n, 1'b0)
            end
         join
         wait_ready();
         `check_eq(boot_cfg, 4'he)
      end
   endtask : ext_hard
   task conclude;
      begin
         if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask : conclude
   initial begin
      repeat (3) @(posedge core_clk);
      #1;
      rst = 1'b0;
      run_seq(4'hb, 1'b1, 1'b1);
      run_seq(4'h5, 1'b0, 1'b1);
      run_seq(4'he, 1'b1, 1'b0);
      ext_hard();
      conclude();
   end
endmodule : test_reset_init_sequencer
